// >>> logic/pct_regs.svh
// register offsets and field positions of the pwm/capture group
// assumes a word-aligned AHB-Lite map decoded on the low address byte
`ifndef PCT_REGS_SVH
`define PCT_REGS_SVH
`define PCT_NCH 4
`define PCT_OFF_PRESCALE 8'h00
`define PCT_OFF_CLKSEL 8'h04
`define PCT_OFF_CTRL 8'h08
`define PCT_OFF_CH0 8'h0c
`define PCT_CH_STRIDE 8'h0c
`define PCT_CMP_OFS 8'h04
`define PCT_LIVE_OFS 8'h08
`define PCT_OFF_IRQEN 8'h40
`define PCT_OFF_IRQIND 8'h44
`define PCT_OFF_CAPCTL0 8'h50
`define PCT_OFF_CAPCTL1 8'h54
`define PCT_OFF_LATCH0 8'h58
`define PCT_LATCH_STRIDE 8'h08
`define PCT_FALL_OFS 8'h04
`define PCT_CTRL_EN_BIT 0
`define PCT_CTRL_MODE_BIT 3
`define PCT_CTRL_DZ_BIT 4
`define PCT_CTRL_STRIDE 8
`define PCT_CAP_RIE_BIT 1
`define PCT_CAP_FIE_BIT 2
`define PCT_CAP_EN_BIT 3
`define PCT_CAP_FLAG_BIT 4
`define PCT_CAP_HALF 16
`define PCT_SEL_STRIDE 4
`define PCT_SEL_MAX 3'h4
`define PCT_ZERO16 16'h0000
`endif

// >>> logic/pct_pkg.sv
// types of the pwm/capture group: bus phase and the whole state record
// assumes four channels in two pairs, 16-bit counters, 8-bit prescalers
package pct_pkg;
    typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_RWAIT, BUS_RDONE} pct_bus_e;
    typedef struct packed {
        pct_bus_e bus;
        logic [7:0] addr;
        logic [31:0] rdata;
        logic [1:0][7:0] pre;
        logic [1:0][7:0] deadzone_interval;
        logic [1:0][7:0] pre_cnt;
        logic [1:0] dz_en;
        logic [3:0][2:0] dsel;
        logic [3:0][3:0] div_cnt;
        logic [3:0] run_en;
        logic [3:0] en_q;
        logic [3:0] mode;
        logic [3:0] running;
        logic [3:0] cap_en;
        logic [3:0] rie;
        logic [3:0] fie;
        logic [3:0] cflag;
        logic [3:0] pflag;
        logic [3:0] ie;
        logic [3:0] out;
        logic [3:0][2:0] cap_sync;
        logic [3:0][7:0] dz_cnt;
        logic [3:0][15:0] period;
        logic [3:0][15:0] cmp;
        logic [3:0][15:0] cmp_act;
        logic [3:0][15:0] cnt;
        logic [3:0][15:0] rlat;
        logic [3:0][15:0] flat;
        logic irq;
    } pct_state_s;
endpackage

// >>> logic/pct_top.sv
// pwm generator and capture timer group: two pairs, four channels
// assumes one AHB-Lite master, pwm clock equal to hclk, async pins on cap_in
`include "pct_regs.svh"
module pct_top
    import pct_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [3:0] cap_in,
    output logic [3:0] pwm_out,
    output logic irq
);
    // ==========================================================
    // helpers
    function automatic logic [3:0] div_mask(input logic [2:0] sel);
        logic [2:0] s;
        s = (sel > `PCT_SEL_MAX) ? `PCT_SEL_MAX : sel;
        div_mask = 4'((5'h01 << s) - 5'h01);
    endfunction

    function automatic logic [31:0] rd_mux(input pct_state_s s, input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0;
        if (a == `PCT_OFF_PRESCALE) begin
            d = {s.deadzone_interval[1], s.deadzone_interval[0], s.pre[1], s.pre[0]};
        end else if (a == `PCT_OFF_CLKSEL) begin
            for (int c = 0; c < `PCT_NCH; c++) begin
                d[c*`PCT_SEL_STRIDE +: 3] = s.dsel[c];
            end
        end else if (a == `PCT_OFF_CTRL) begin
            for (int c = 0; c < `PCT_NCH; c++) begin
                d[c*`PCT_CTRL_STRIDE + `PCT_CTRL_EN_BIT] = s.run_en[c];
                d[c*`PCT_CTRL_STRIDE + `PCT_CTRL_MODE_BIT] = s.mode[c];
            end
            d[`PCT_CTRL_DZ_BIT +: 2] = s.dz_en;
        end else if (a == `PCT_OFF_IRQEN) begin
            d[3:0] = s.ie;
        end else if (a == `PCT_OFF_IRQIND) begin
            d[3:0] = s.pflag;
        end else if (a == `PCT_OFF_CAPCTL0 || a == `PCT_OFF_CAPCTL1) begin
            for (int h = 0; h < 2; h++) begin
                int c;
                c = (a == `PCT_OFF_CAPCTL1) ? h + 2 : h;
                d[h*`PCT_CAP_HALF + `PCT_CAP_RIE_BIT] = s.rie[c];
                d[h*`PCT_CAP_HALF + `PCT_CAP_FIE_BIT] = s.fie[c];
                d[h*`PCT_CAP_HALF + `PCT_CAP_EN_BIT] = s.cap_en[c];
                d[h*`PCT_CAP_HALF + `PCT_CAP_FLAG_BIT] = s.cflag[c];
            end
        end else begin
            for (int c = 0; c < `PCT_NCH; c++) begin
                logic [7:0] b;
                logic [7:0] l;
                b = 8'(`PCT_OFF_CH0 + c * `PCT_CH_STRIDE);
                l = 8'(`PCT_OFF_LATCH0 + c * `PCT_LATCH_STRIDE);
                if (a == b) d[15:0] = s.period[c];
                if (a == 8'(b + `PCT_CMP_OFS)) d[15:0] = s.cmp[c];
                if (a == 8'(b + `PCT_LIVE_OFS)) d[15:0] = s.cnt[c];
                if (a == l) d[15:0] = s.rlat[c];
                if (a == 8'(l + `PCT_FALL_OFS)) d[15:0] = s.flat[c];
            end
        end
        rd_mux = d;
    endfunction

    // ==========================================================
    // state
    pct_state_s state_reg;
    pct_state_s state_next;
    logic [1:0] ptick;
    logic [3:0] tick;
    logic [3:0] raw;
    logic [3:0] src;
    logic [3:0] rise;
    logic [3:0] fall;

    // ==========================================================
    // next state
    always_comb begin
        state_next = state_reg;
        ptick = 2'h0;
        tick = 4'h0;
        raw = 4'h0;
        src = 4'h0;
        rise = 4'h0;
        fall = 4'h0;
        // bus: reads insert one wait so a preceding write is always visible
        case (state_reg.bus)
            BUS_RWAIT: begin
                state_next.rdata = rd_mux(state_reg, state_reg.addr);
                state_next.bus = BUS_RDONE;
            end
            default: begin
                if (hsel && hready && htrans[1]) begin
                    state_next.addr = haddr[7:0];
                    state_next.bus = hwrite ? BUS_WRITE : BUS_RWAIT;
                end else begin
                    state_next.bus = BUS_IDLE;
                end
            end
        endcase
        if (state_reg.bus == BUS_WRITE) begin
            if (state_reg.addr == `PCT_OFF_PRESCALE) begin
                {state_next.deadzone_interval[1], state_next.deadzone_interval[0]} = hwdata[31:16];
                {state_next.pre[1], state_next.pre[0]} = hwdata[15:0];
            end else if (state_reg.addr == `PCT_OFF_CLKSEL) begin
                for (int c = 0; c < `PCT_NCH; c++) begin
                    state_next.dsel[c] = hwdata[c*`PCT_SEL_STRIDE +: 3];
                end
            end else if (state_reg.addr == `PCT_OFF_CTRL) begin
                for (int c = 0; c < `PCT_NCH; c++) begin
                    state_next.run_en[c] = hwdata[c*`PCT_CTRL_STRIDE + `PCT_CTRL_EN_BIT];
                    state_next.mode[c] = hwdata[c*`PCT_CTRL_STRIDE + `PCT_CTRL_MODE_BIT];
                end
                state_next.dz_en = hwdata[`PCT_CTRL_DZ_BIT +: 2];
            end else if (state_reg.addr == `PCT_OFF_IRQEN) begin
                state_next.ie = hwdata[3:0];
            end else if (state_reg.addr == `PCT_OFF_IRQIND) begin
                state_next.pflag = state_reg.pflag & ~hwdata[3:0];
            end else if (state_reg.addr == `PCT_OFF_CAPCTL0
                         || state_reg.addr == `PCT_OFF_CAPCTL1) begin
                for (int h = 0; h < 2; h++) begin
                    int c;
                    c = (state_reg.addr == `PCT_OFF_CAPCTL1) ? h + 2 : h;
                    state_next.rie[c] = hwdata[h*`PCT_CAP_HALF + `PCT_CAP_RIE_BIT];
                    state_next.fie[c] = hwdata[h*`PCT_CAP_HALF + `PCT_CAP_FIE_BIT];
                    state_next.cap_en[c] = hwdata[h*`PCT_CAP_HALF + `PCT_CAP_EN_BIT];
                    if (hwdata[h*`PCT_CAP_HALF + `PCT_CAP_FLAG_BIT]) begin
                        state_next.cflag[c] = 1'b0;
                    end
                end
            end else begin
                for (int c = 0; c < `PCT_NCH; c++) begin
                    logic [7:0] b;
                    b = 8'(`PCT_OFF_CH0 + c * `PCT_CH_STRIDE);
                    if (state_reg.addr == b) state_next.period[c] = hwdata[15:0];
                    if (state_reg.addr == 8'(b + `PCT_CMP_OFS)) begin
                        state_next.cmp[c] = hwdata[15:0];
                    end
                end
            end
        end
        // prescaler per pair, runs only while a channel of the pair has run_en set
        for (int p = 0; p < 2; p++) begin
            logic act;
            act = state_reg.run_en[2*p] | state_reg.run_en[2*p+1];
            ptick[p] = act && state_reg.pre_cnt[p] == state_reg.pre[p];
            state_next.pre_cnt[p] = (!act || ptick[p]) ? 8'h00 : 8'(state_reg.pre_cnt[p] + 8'h01);
        end
        // channel timers; hardware sets after software clears, so set wins
        for (int c = 0; c < `PCT_NCH; c++) begin
            logic [3:0] m;
            m = div_mask(state_reg.dsel[c]);
            tick[c] = ptick[c/2] && (state_reg.div_cnt[c] & m) == m;
            state_next.div_cnt[c] = (!state_reg.run_en[c] || tick[c]) ? 4'h0
                : 4'(state_reg.div_cnt[c] + {3'h0, ptick[c/2]});
            state_next.en_q[c] = state_reg.run_en[c];
            if (!state_reg.run_en[c]) begin
                state_next.running[c] = 1'b0;
            end else if (!state_reg.en_q[c]) begin
                state_next.cnt[c] = state_reg.period[c];
                state_next.cmp_act[c] = state_reg.cmp[c];
                state_next.running[c] = 1'b1;
            end else if (state_reg.running[c] && tick[c]) begin
                if (state_reg.cnt[c] == `PCT_ZERO16) begin
                    if (state_reg.mode[c] && state_reg.period[c] != `PCT_ZERO16) begin
                        state_next.cnt[c] = state_reg.period[c];
                        state_next.cmp_act[c] = state_reg.cmp[c];
                    end else begin
                        state_next.running[c] = 1'b0;
                    end
                end else begin
                    state_next.cnt[c] = 16'(state_reg.cnt[c] - 16'h0001);
                    if (state_reg.cnt[c] == 16'h0001) begin
                        state_next.pflag[c] = 1'b1;
                    end
                end
            end
            // capture: first sync stage feeds only the second
            state_next.cap_sync[c] = {state_reg.cap_sync[c][1:0], cap_in[c]};
            rise[c] = state_reg.cap_sync[c][1] && !state_reg.cap_sync[c][2];
            fall[c] = !state_reg.cap_sync[c][1] && state_reg.cap_sync[c][2];
            if (state_reg.cap_en[c] && rise[c]) begin
                state_next.rlat[c] = state_reg.cnt[c];
                if (state_reg.rie[c]) begin
                    state_next.cflag[c] = 1'b1;
                    state_next.cnt[c] = state_reg.period[c];
                end
            end
            if (state_reg.cap_en[c] && fall[c]) begin
                state_next.flat[c] = state_reg.cnt[c];
                if (state_reg.fie[c]) begin
                    state_next.cflag[c] = 1'b1;
                    state_next.cnt[c] = state_reg.period[c];
                end
            end
            // high from compare match down to zero: cmp+1 units high
            raw[c] = state_reg.running[c] && !state_reg.cap_en[c]
                && state_reg.cnt[c] <= state_reg.cmp_act[c];
        end
        // dead zone: counted in hclk cycles, not pwm units
        for (int c = 0; c < `PCT_NCH; c++) begin
            logic dz;
            dz = state_reg.dz_en[c/2];
            src[c] = raw[c];
            if (dz && c[0]) begin
                src[c] = state_reg.running[2*(c/2)] && !raw[2*(c/2)];
            end
            if (!src[c]) begin
                state_next.dz_cnt[c] = state_reg.deadzone_interval[c/2];
                state_next.out[c] = 1'b0;
            end else if (dz && state_reg.dz_cnt[c] != 8'h00) begin
                state_next.dz_cnt[c] = 8'(state_reg.dz_cnt[c] - 8'h01);
                state_next.out[c] = 1'b0;
            end else begin
                state_next.out[c] = 1'b1;
            end
        end
        state_next.irq = |((state_next.pflag & state_next.ie) | state_next.cflag);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign hreadyout = state_reg.bus != BUS_RWAIT;
    assign hrdata = state_reg.rdata;
    assign hresp = 1'b0;
    assign pwm_out = state_reg.out;
    assign irq = state_reg.irq;

    // ==========================================================
    // checks
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_STOP_NOW: assert property (!state_reg.run_en[0] |=> !state_reg.running[0])
        else $error("channel still running after enable cleared");
    AST_HALT_ZERO: assert property (state_reg.running[0] && state_reg.en_q[0] && tick[0]
        && state_reg.cnt[0] == 16'h0 && state_reg.period[0] == 16'h0
        |=> !state_reg.running[0] && state_reg.cnt[0] == 16'h0)
        else $error("counter did not halt on zero period");
    AST_ONE_SHOT: assert property (state_reg.run_en[0] && state_reg.en_q[0] && tick[0]
        && state_reg.running[0] && state_reg.cnt[0] == 16'h0 && !state_reg.mode[0]
        |=> !state_reg.running[0])
        else $error("one-shot counter did not stop");
    AST_RELOAD: assert property (state_reg.run_en[0] && state_reg.en_q[0] && tick[0]
        && state_reg.running[0] && state_reg.cnt[0] == 16'h0 && state_reg.mode[0]
        && state_reg.period[0] != 16'h0
        |=> state_reg.cnt[0] == $past(state_reg.period[0]) && state_reg.running[0])
        else $error("counter not reloaded from period");
    AST_DOWN: assert property (state_reg.run_en[0] && state_reg.en_q[0] && tick[0]
        && state_reg.running[0] && state_reg.cnt[0] != 16'h0 && !state_reg.cap_en[0]
        |=> state_reg.cnt[0] == 16'($past(state_reg.cnt[0]) - 16'h0001))
        else $error("counter did not step down by one");
    AST_ZERO_FLAG: assert property (state_reg.run_en[0] && state_reg.en_q[0] && tick[0]
        && state_reg.running[0] && state_reg.cnt[0] == 16'h1
        |=> state_reg.pflag[0] ##1 (state_reg.pflag[0] || $past(state_reg.bus) == BUS_WRITE))
        else $error("period flag not set at zero");
    AST_RISE_LATCH: assert property (state_reg.cap_en[0] && rise[0]
        |=> state_reg.rlat[0] == $past(state_reg.cnt[0]))
        else $error("rising capture not latched");
    AST_CAP_RELOAD: assert property (state_reg.cap_en[0] && fall[0] && state_reg.fie[0]
        |=> state_reg.cflag[0] && state_reg.cnt[0] == $past(state_reg.period[0]))
        else $error("capture irq did not reload counter");
    AST_IRQ_SHARED: assert property ((state_reg.cflag[0] || state_reg.pflag[0]
        && state_reg.ie[0]) |-> irq)
        else $error("group irq missing");
    AST_HIGH: assert property (state_reg.running[0] && !state_reg.cap_en[0]
        && !state_reg.dz_en[0] && state_reg.cnt[0] <= state_reg.cmp_act[0]
        |=> pwm_out[0])
        else $error("output not high at or below compare");

    // a period write must not touch the live count; only the next reload uses it
    AST_PERIOD_HOLD: assert property (state_reg.bus == BUS_WRITE
        && state_reg.addr == `PCT_OFF_CH0 && state_reg.run_en[0] && state_reg.en_q[0]
        && state_reg.running[0] && state_reg.cnt[0] != 16'h0 && !state_reg.cap_en[0]
        |=> state_reg.cnt[0] == 16'($past(state_reg.cnt[0]) - {15'h0, $past(tick[0])}))
        else $error("period write disturbed the running count");

    AST_CMP_HOLD: assert property (state_reg.run_en[0] && state_reg.en_q[0]
        && !(tick[0] && state_reg.cnt[0] == 16'h0)
        |=> state_reg.cmp_act[0] == $past(state_reg.cmp_act[0]))
        else $error("active compare changed inside a period");

    AST_DIV_ONE: assert property (ptick[0] && state_reg.run_en[0]
        && state_reg.dsel[0] == 3'h0 |-> tick[0])
        else $error("divide-by-one setting skipped a tick");

    AST_DIV_SIXTEEN: assert property (state_reg.dsel[0] == 3'h4 && tick[0]
        |-> state_reg.div_cnt[0] == 4'hf)
        else $error("divide-by-sixteen tick came early");

    AST_PRE_TICK: assert property (tick[0] |-> state_reg.pre_cnt[0] == state_reg.pre[0])
        else $error("channel tick without prescaler wrap");

    AST_DZ_GAP: assert property (state_reg.dz_en[0] && state_reg.dz_cnt[0] != 8'h00
        |=> !pwm_out[0])
        else $error("rising edge not held back by the dead zone");

    AST_PAIR_COMP: assert property (state_reg.dz_en[0] && state_reg.running[0]
        && state_reg.dz_cnt[0] == 8'h00 && state_reg.dz_cnt[1] == 8'h00
        |=> pwm_out[1] == !pwm_out[0])
        else $error("paired outputs not complementary");

    AST_CAPTURE_QUIET: assert property (state_reg.cap_en[0] |=> !pwm_out[0])
        else $error("output driven while the channel captures");
endmodule

// >>> verif/pct_pins_model.sv
// pin-side partner: pulse source on cap_in[0], run-length meter on pwm_out[0]
// assumes hclk is also the pwm clock; the bench sets half_len and go
module pct_pins_model (
    input wire logic hclk,
    input wire logic [3:0] pwm_out,
    input wire logic [15:0] half_len,
    input wire logic go,
    output logic [3:0] cap_in,
    output logic [15:0] hi_len,
    output logic [15:0] lo_len,
    output logic [15:0] per_len
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] run;
    logic [15:0] prun;
    logic [15:0] wave;
    logic last;
    initial begin
        cap_in = 4'h0;
        hi_len = 16'h0000;
        lo_len = 16'h0000;
        per_len = 16'h0000;
        run = 16'h0000;
        prun = 16'h0000;
        wave = 16'h0000;
        last = 1'b0;
    end
    // ====================
    // meter: last completed high, low and rise-to-rise lengths
    always @(posedge hclk) begin
        if (pwm_out[0] !== last) begin
            if (last) hi_len <= run;
            else lo_len <= run;
            run <= 16'h0001;
        end else begin
            run <= run + 16'h0001;
        end
        if (pwm_out[0] === 1'b1 && last === 1'b0) begin
            per_len <= prun;
            prun <= 16'h0001;
        end else begin
            prun <= prun + 16'h0001;
        end
        last <= pwm_out[0];
        // ====================
        // source: square wave; holds its level while go is low so the
        // handler latency sees no toggle
        if (go && wave == half_len - 16'h0001) begin
            wave <= 16'h0000;
            cap_in[0] <= ~cap_in[0];
        end else if (go) begin
            wave <= wave + 16'h0001;
        end else begin
            wave <= 16'h0000;
        end
    end
endmodule

// >>> verif/pwm_capture_timer_tb_top.sv
// bench of the pwm/capture group: AHB-Lite tasks, waveform and capture tests
// assumes pct_top with hready looped back and the pin model on its pins
`include "pct_regs.svh"
module pwm_capture_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] per0 = `PCT_OFF_CH0;
    localparam logic [7:0] cmp0 = `PCT_OFF_CH0 + `PCT_CMP_OFS;
    localparam logic [7:0] live0 = `PCT_OFF_CH0 + `PCT_LIVE_OFS;
    localparam logic [7:0] rlat0 = `PCT_OFF_LATCH0;
    localparam logic [7:0] flat0 = `PCT_OFF_LATCH0 + `PCT_FALL_OFS;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic [3:0] cap_in;
    logic [3:0] pwm_out;
    logic irq;
    logic go = 1'b0;
    logic [15:0] hi_len;
    logic [15:0] lo_len;
    logic [15:0] per_len;
    int failures = 0;
    int n_compared = 0;
    always #5 hclk = ~hclk;
    pct_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .cap_in(cap_in), .pwm_out(pwm_out), .irq(irq));
    pct_pins_model pins (.hclk(hclk), .pwm_out(pwm_out), .half_len(16'h0014),
        .go(go), .cap_in(cap_in), .hi_len(hi_len), .lo_len(lo_len), .per_len(per_len));
    // ====================
    // tasks
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one single transfer; waits on hready, and fails the run after 40 cycles
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r);
        int n;
        n = 0;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        r = hrdata;
        if (n >= 40) begin
            failures++;
            end_sim();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(a, 1'b0, 32'h0, r);
        check(r, e);
    endtask
    task automatic start(input logic [15:0] p, input logic [15:0] c, input logic [31:0] ctl);
        wr(`PCT_OFF_CTRL, 32'h0);
        wr(cmp0, {16'h0000, c});
        wr(per0, {16'h0000, p});
        wr(`PCT_OFF_CTRL, ctl);
    endtask
    task automatic watch(input int n, output int hi, output int rises, output int same);
        logic p;
        hi = 0;
        rises = 0;
        same = 0;
        p = pwm_out[0];
        repeat (n) begin
            @(posedge hclk);
            hi += (pwm_out[0] === 1'b1);
            rises += (pwm_out[0] === 1'b1 && p !== 1'b1);
            same += (pwm_out[1] === pwm_out[0]);
            p = pwm_out[0];
        end
    endtask
    // ====================
    // main sequence
    initial begin
        logic [31:0] r;
        int hi, rises, same, d;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(`PCT_OFF_PRESCALE, 32'h0);
        rdc(`PCT_OFF_CTRL, 32'h0);
        rdc(rlat0, 32'h0);
        rdc(`PCT_OFF_IRQIND, 32'h0);
        check(hresp, 1'b0);
        check(hreadyout, 1'b1);
        wr(8'h80, 32'hffffffff);
        rdc(8'h80, 32'h0);
        wr(per0, 32'h1234);
        rdc(per0, 32'h1234);
        rdc(live0, 32'h0);
        start(16'h4, 16'h1, 32'h9);
        repeat (30) @(posedge hclk);
        check(hi_len, 16'h2);
        check(lo_len, 16'h3);
        // compare rewritten mid-run, no stop
        wr(cmp0, 32'h0);
        repeat (30) @(posedge hclk);
        check(hi_len, 16'h1);
        check(lo_len, 16'h4);
        start(16'h4, 16'h4, 32'h9);
        // output lags the enable write by two edges
        repeat (3) @(posedge hclk);
        watch(30, hi, rises, same);
        check(hi, 30);
        wr(`PCT_OFF_PRESCALE, 32'h1);
        start(16'h3, 16'h1, 32'h9);
        for (int k = 0; k < 5; k++) begin
            wr(`PCT_OFF_CLKSEL, k);
            repeat (30 << k) @(posedge hclk);
            check(per_len, 8 << k);
            check(hi_len, 4 << k);
        end
        wr(`PCT_OFF_PRESCALE, 32'h0);
        wr(`PCT_OFF_CLKSEL, 32'h0);
        wr(`PCT_OFF_CTRL, 32'h0);
        wr(`PCT_OFF_IRQIND, 32'hf);
        wr(`PCT_OFF_IRQEN, 32'h1);
        start(16'h4, 16'h1, 32'h1);
        watch(30, hi, rises, same);
        check(rises, 1);
        rdc(live0, 32'h0);
        rdc(`PCT_OFF_IRQIND, 32'h1);
        check(irq, 1'b1);
        wr(`PCT_OFF_IRQIND, 32'h1);
        rdc(`PCT_OFF_IRQIND, 32'h0);
        check(irq, 1'b0);
        start(16'h4, 16'h1, 32'h9);
        repeat (12) @(posedge hclk);
        wr(per0, 32'h0);
        repeat (20) @(posedge hclk);
        rdc(live0, 32'h0);
        watch(20, hi, rises, same);
        check(rises, 0);
        start(16'h4, 16'h8, 32'h9);
        repeat (10) @(posedge hclk);
        check(pwm_out[0], 1'b1);
        wr(`PCT_OFF_CTRL, 32'h0);
        repeat (3) @(posedge hclk);
        check(pwm_out[0], 1'b0);
        wr(8'h28, 32'h8);
        wr(8'h24, 32'h4);
        wr(`PCT_OFF_CTRL, 32'h00090000);
        repeat (5) @(posedge hclk);
        check(pwm_out, 4'h4);
        start(16'h4, 16'h1, 32'h19);
        repeat (5) @(posedge hclk);
        watch(30, hi, rises, same);
        check(same, 0);
        wr(`PCT_OFF_PRESCALE, 32'h00020000);
        wr(cmp0, 32'h2);
        repeat (30) @(posedge hclk);
        check(hi_len, 16'h1);
        check(lo_len, 16'h4);
        // ====================
        // capture: both edges interrupt, so every edge reloads the counter
        wr(`PCT_OFF_PRESCALE, 32'h0);
        wr(`PCT_OFF_IRQEN, 32'h0);
        wr(`PCT_OFF_CAPCTL0, 32'he);
        start(16'hff, 16'h0, 32'h9);
        go <= 1'b1;
        repeat (130) @(posedge hclk);
        go <= 1'b0;
        repeat (10) @(posedge hclk);
        bus(rlat0, 1'b0, 32'h0, r);
        d = 256 - r;
        check(d >= 19 && d <= 21, 1'b1);
        bus(flat0, 1'b0, 32'h0, r);
        d = 256 - r;
        check(d >= 19 && d <= 21, 1'b1);
        rdc(`PCT_OFF_CAPCTL0, 32'h1e);
        check(irq, 1'b1);
        wr(`PCT_OFF_CAPCTL0, 32'h1e);
        rdc(`PCT_OFF_CAPCTL0, 32'he);
        check(irq, 1'b0);
        wr(`PCT_OFF_CAPCTL0, 32'h8);
        go <= 1'b1;
        repeat (80) @(posedge hclk);
        go <= 1'b0;
        rdc(`PCT_OFF_CAPCTL0, 32'h8);
        check(irq, 1'b0);
        end_sim();
    end
endmodule
